// file: dcsc_pkg.sv
// Constants shared by both ends of the dual card serial control link.
// Assumes a 25 MHz system clock at each end and a slow serial clock.
// ----------------------------------------------------------------------
// Overview of operation
// - Interrupt line high after reset
// - Insertion, removal or supply fault pulls interrupt low
// - Interrupt independent of select and address
// - Nonzero supply code clears insertion interrupt
// - Zero supply code clears removal/fault interrupt
// - Per-port poll returns prior port status
// - Host compares status, polls devices separately
// - Removal raises interrupt and starts power-down
// - Reinsertion before acknowledge keeps interrupt low
// - Slave only; serial clock idles low or high
// - Command register in, status register out
// - Select high ignores all serial activity
// - Select fall clears shifter, enables lines
// - Data valid by fall, shifted on rise
// - First three bits decoded as chip address
// - Select rise latches command, updates functions
// - Several bytes per frame, each decoded separately
// - Host leaves gap between byte bursts
// - Status bit four high when card present
// - Status bit three shows card data level
// ----------------------------------------------------------------------
package dcsc_pkg;
  localparam int BYTE_W = 8;
  localparam int CTRL_W = 5;
  localparam int NPORT = 2;
  localparam int BANK_BIT = 7;
  localparam int CHIP_BIT = 6;
  localparam int PORT_BIT = 5;
  localparam int ADDR_LAST_CNT = 2;
  localparam int BYTE_LAST_CNT = 7;
  localparam logic BANK_VALUE = 1'b0;
  localparam int ST_PRES = 4;
  localparam int ST_IO = 3;
  localparam int ST_FAULT = 2;
  localparam int SUP_HI = 1;
  localparam int SUP_LO = 0;
  localparam logic [1:0] SUP_OFF = 2'h0;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int ARM_CYC = 3;
endpackage

// file: dcsc_spi_if.sv
// Serial control link between host and dual card device.
// The data-out line is open-drain like; undriven it reads low.
`timescale 1ns/10ps
interface dcsc_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic int_n;
  logic miso;
  assign miso = miso_oe & miso_o;
  modport device (
    input sclk,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe,
    output int_n
  );
  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    input int_n
  );
endinterface

// file: dcsc_card_dev.sv
// Device end: serial slave, per-port command and status, interrupt.
// Assumes every link and card input is asynchronous to clk.
`timescale 1ns/10ps
module dcsc_card_dev (
  input wire logic clk,
  input wire logic reset,
  dcsc_spi_if.device spi,
  input wire logic hw_address_pin,
  input wire logic [1:0] card_detect_switch,
  input wire logic [1:0] det_present_high,
  input wire logic [1:0] card_io_level,
  input wire logic [1:0] supply_fault,
  output logic [3:0] card_supply,
  output logic [5:0] card_ctrl,
  output logic [1:0] card_deactivation_seq
);
  localparam int SYNC_W = 12;
  localparam logic [SYNC_W-1:0] SYNC_RST = 12'h002;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  wire [SYNC_W-1:0] raw_in = {det_present_high, supply_fault,
    card_io_level, card_detect_switch, hw_address_pin, spi.mosi,
    spi.cs_n, spi.sclk};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end
    else
    begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  wire s_sclk = sync_ff[0];
  wire s_cs_n = sync_ff[1];
  wire s_mosi = sync_ff[2];
  wire s_addr = sync_ff[3];
  wire [1:0] s_det = sync_ff[5:4];
  wire [1:0] s_io = sync_ff[7:6];
  wire [1:0] s_fault = sync_ff[9:8];
  wire [1:0] s_pol = sync_ff[11:10];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_q_ff;
  logic cs_q_ff;

  wire in_frame = ~s_cs_n & ~cs_q_ff;
  wire cs_fall = ~s_cs_n & cs_q_ff;
  wire cs_rise = s_cs_n & ~cs_q_ff;
  wire sclk_rise = in_frame & s_sclk & ~sclk_q_ff;
  wire sclk_fall = in_frame & ~s_sclk & sclk_q_ff;

  // ----------------------------------------------------------------
  // Shift register and address decode
  // ----------------------------------------------------------------
  logic [dcsc_pkg::BYTE_W-1:0] shift_ff;
  logic [2:0] cnt_ff;
  logic sel_ff;
  logic port_ff;
  logic [dcsc_pkg::CTRL_W-1:0] st_sh_ff;
  logic miso_ff;
  logic oe_ff;
  logic [2*dcsc_pkg::CTRL_W-1:0] pend_ff;
  logic [1:0] pvld_ff;
  logic [2*dcsc_pkg::CTRL_W-1:0] st_all;

  wire [dcsc_pkg::BYTE_W-1:0] shift_in = {shift_ff[6:0], s_mosi};
  wire addr_done = sclk_rise & (cnt_ff == 3'(dcsc_pkg::ADDR_LAST_CNT));
  wire byte_done = sclk_rise & (cnt_ff == 3'(dcsc_pkg::BYTE_LAST_CNT));
  // At the third rise the low bits hold b7, b6, b5
  wire addr_hit = (shift_in[2] == dcsc_pkg::BANK_VALUE) &
    (shift_in[1] == s_addr);
  wire addr_port = shift_in[0];
  wire [dcsc_pkg::CTRL_W-1:0] port_st =
    addr_port ? st_all[9:5] : st_all[4:0];
  wire out_slot = sel_ff & (cnt_ff >= 3'(dcsc_pkg::ADDR_LAST_CNT + 1));
  wire [2*dcsc_pkg::CTRL_W-1:0] pend_mask =
    port_ff ? 10'h3E0 : 10'h01F;
  wire [2*dcsc_pkg::CTRL_W-1:0] pend_word = {2{shift_in[4:0]}};
  wire pend_load = byte_done & sel_ff;
  wire [2*dcsc_pkg::CTRL_W-1:0] nxt_pend =
    pend_load ? ((pend_ff & ~pend_mask) | (pend_word & pend_mask))
    : pend_ff;
  wire [1:0] nxt_pvld = cs_rise ? 2'h0
    : pend_load ? (pvld_ff | (port_ff ? 2'h2 : 2'h1)) : pvld_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shift_ff <= 8'h00;
      cnt_ff <= 3'h0;
      sel_ff <= 1'b0;
      port_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_ff <= 8'h00;
      cnt_ff <= 3'h0;
      sel_ff <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shift_ff <= shift_in;
      cnt_ff <= cnt_ff + 3'h1;
      if (addr_done)
      begin
        sel_ff <= addr_hit;
        port_ff <= addr_port;
      end
      else if (byte_done)
      begin
        sel_ff <= 1'b0;
      end
    end
  end

  // Status leaves on falling edges, host reads it before the next one
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_sh_ff <= 5'h00;
      miso_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      miso_ff <= 1'b0;
    end
    else if (addr_done)
    begin
      st_sh_ff <= port_st;
    end
    else if (sclk_fall & out_slot)
    begin
      miso_ff <= st_sh_ff[4];
      st_sh_ff <= {st_sh_ff[3:0], 1'b0};
    end
  end

  // Drive only while addressed, so a second device can share the line
  // Either idle level works: only edges inside a frame count
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
      oe_ff <= 1'b0;
      pend_ff <= 10'h000;
      pvld_ff <= 2'h0;
    end
    else
    begin
      sclk_q_ff <= s_sclk;
      cs_q_ff <= s_cs_n;
      oe_ff <= ~s_cs_n & sel_ff;
      pend_ff <= nxt_pend;
      pvld_ff <= nxt_pvld;
    end
  end

  assign spi.miso_o = miso_ff;
  assign spi.miso_oe = oe_ff;

  // ----------------------------------------------------------------
  // Card ports
  // ----------------------------------------------------------------
  logic [1:0] arm_ff;
  wire armed = (arm_ff == 2'(dcsc_pkg::ARM_CYC));
  logic [1:0] flag_any;
  logic int_n_ff;

  // Synchroniser contents are stale for the first cycles after reset
  // Interrupt not gated by select or address: it may fall mid-frame
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arm_ff <= 2'h0;
      int_n_ff <= 1'b1;
    end
    else
    begin
      arm_ff <= armed ? arm_ff : arm_ff + 2'h1;
      int_n_ff <= ~(|flag_any);
    end
  end

  genvar p;
  generate
    for (p = 0; p < dcsc_pkg::NPORT; p++)
    begin : g_port
      logic pres_q_ff;
      logic flt_q_ff;
      logic ins_ff;
      logic ext_ff;
      logic dq_ff;
      logic [1:0] sup_ff;
      logic [2:0] ctl_ff;
      wire pres = s_det[p] ~^ s_pol[p];
      wire ins_ev = armed & pres & ~pres_q_ff;
      wire ext_ev = armed & ~pres & pres_q_ff;
      wire ovl_ev = armed & s_fault[p] & ~flt_q_ff;
      wire down_ev = ext_ev | ovl_ev;
      wire commit = cs_rise & pvld_ff[p];
      wire [4:0] cmd = pend_ff[p*dcsc_pkg::CTRL_W +: dcsc_pkg::CTRL_W];
      wire sup_zero = (cmd[dcsc_pkg::SUP_HI:dcsc_pkg::SUP_LO] ==
        dcsc_pkg::SUP_OFF);
      wire clr_ins = commit & ~sup_zero;
      wire clr_ext = commit & sup_zero;

      // New events win over a clear in the same cycle
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          pres_q_ff <= 1'b0;
          flt_q_ff <= 1'b0;
          ins_ff <= 1'b0;
          ext_ff <= 1'b0;
          dq_ff <= 1'b0;
        end
        else
        begin
          pres_q_ff <= pres;
          flt_q_ff <= s_fault[p];
          ins_ff <= ins_ev | (ins_ff & ~clr_ins);
          ext_ff <= down_ev | (ext_ff & ~clr_ext);
          dq_ff <= down_ev;
        end
      end

      // Power-down overrides a command committed in the same cycle
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          sup_ff <= dcsc_pkg::SUP_OFF;
          ctl_ff <= 3'h0;
        end
        else if (down_ev)
        begin
          sup_ff <= dcsc_pkg::SUP_OFF;
        end
        else if (commit)
        begin
          sup_ff <= cmd[dcsc_pkg::SUP_HI:dcsc_pkg::SUP_LO];
          ctl_ff <= cmd[4:2];
        end
      end

      assign st_all[p*dcsc_pkg::CTRL_W +: dcsc_pkg::CTRL_W] =
        {pres, s_io[p], s_fault[p], sup_ff};
      assign flag_any[p] = ins_ff | ext_ff;
      assign card_supply[2*p +: 2] = sup_ff;
      assign card_ctrl[3*p +: 3] = ctl_ff;
      assign card_deactivation_seq[p] = dq_ff;
    end
  endgenerate

  assign spi.int_n = int_n_ff;
endmodule // dcsc_card_dev

// file: dcsc_card_host.sv
// Host end: serial master sending one command byte per frame.
// Assumes the device samples data on rising serial clock edges.
`timescale 1ns/10ps
module dcsc_card_host #(
  parameter int HALF_CYC = dcsc_pkg::SCLK_HALF_CYC,
  parameter logic SCLK_IDLE = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  dcsc_spi_if.host spi,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic int_pending
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP = 3'b101
  } dcsc_hst_type;

  dcsc_hst_type st_ff;
  logic [7:0] tim_ff;
  logic [2:0] bit_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic mosi_ff;
  logic ready_ff;
  logic rv_ff;
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff <= 2'h2;
      sync_ff <= 2'h2;
    end
    else
    begin
      meta_ff <= {spi.int_n, spi.miso};
      sync_ff <= meta_ff;
    end
  end

  wire s_miso = sync_ff[0];
  wire half_done = (tim_ff == 8'(HALF_CYC - 1));
  wire take = cmd_valid & ready_ff;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Sampling late in the high phase covers both synchroniser delays
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= H_IDLE;
      tim_ff <= 8'h00;
      bit_ff <= 3'h0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      sclk_ff <= SCLK_IDLE;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      ready_ff <= 1'b1;
      rv_ff <= 1'b0;
    end
    else
    begin
      rv_ff <= 1'b0;
      tim_ff <= half_done ? 8'h00 : tim_ff + 8'h01;
      case (st_ff)
        H_IDLE:
        begin
          tim_ff <= 8'h00;
          if (take)
          begin
            tx_ff <= cmd_byte;
            cs_n_ff <= 1'b0;
            ready_ff <= 1'b0;
            bit_ff <= 3'h0;
            st_ff <= H_LEAD;
          end
        end
        H_LEAD:
        begin
          if (half_done)
          begin
            sclk_ff <= 1'b0;
            mosi_ff <= tx_ff[7];
            st_ff <= H_LOW;
          end
        end
        H_LOW:
        begin
          if (half_done)
          begin
            sclk_ff <= 1'b1;
            st_ff <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          if (half_done)
          begin
            rx_ff <= {rx_ff[6:0], s_miso};
            tx_ff <= {tx_ff[6:0], 1'b0};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7)
            begin
              sclk_ff <= SCLK_IDLE;
              st_ff <= H_TAIL;
            end
            else
            begin
              sclk_ff <= 1'b0;
              mosi_ff <= tx_ff[6];
              st_ff <= H_LOW;
            end
          end
        end
        H_TAIL:
        begin
          if (half_done)
          begin
            cs_n_ff <= 1'b1;
            rv_ff <= 1'b1;
            st_ff <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (half_done)
          begin
            ready_ff <= 1'b1;
            st_ff <= H_IDLE;
          end
        end
        default:
        begin
          st_ff <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      int_pending <= 1'b0;
    end
    else
    begin
      int_pending <= ~sync_ff[1];
    end
  end

  assign spi.sclk = sclk_ff;
  assign spi.cs_n = cs_n_ff;
  assign spi.mosi = mosi_ff;
  assign cmd_ready = ready_ff;
  assign rsp_valid = rv_ff;
  assign rsp_byte = rx_ff;
endmodule // dcsc_card_host

// file: dcsc_assertions.sv
// Concurrent checks on the serial link between host and device ends.
// Assumes the link pins change only on edges of the same clk.
`timescale 1ns/10ps
module dcsc_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic int_n
);
  // --------------------------------------------------------------
  // Serial clock rises counted within one frame
  // --------------------------------------------------------------
  logic [3:0] rises_ff;
  logic sclk_q_ff;
  logic [3:0] nxt_rises;
  logic sclk_rise;
  assign sclk_rise = sclk & ~sclk_q_ff;
  assign nxt_rises = cs_n ? 4'h0 : rises_ff + {3'h0, sclk_rise};
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rises_ff <= 4'h0;
      sclk_q_ff <= 1'b0;
    end
    else
    begin
      rises_ff <= nxt_rises;
      sclk_q_ff <= sclk;
    end
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_int_reset_high:
    assert property ($fell(reset) |-> int_n)
    else $error("interrupt low right after reset");
  a_oe_in_frame:
    assert property (miso_oe |-> !cs_n)
    else $error("data out driven outside a frame");
  a_oe_quiet_start:
    assert property ($fell(cs_n) |-> (!miso_oe) [*8])
    else $error("data out driven before address decode");
  a_mosi_hold_rise:
    assert property (!cs_n && $rose(sclk) |-> $stable(mosi))
    else $error("host data moved at serial clock rise");
  // Either idle level: the clock must rest before select rises
  a_gap_before_cs:
    assert property ($rose(cs_n) |-> $stable(sclk) && sclk == $past(sclk, 3))
    else $error("select rose without idle clock gap");
  a_oe_after_addr:
    assert property ($rose(miso_oe) |-> rises_ff == 4'h3)
    else $error("data out enabled at wrong bit");
  a_oe_end_byte:
    assert property ($fell(miso_oe) |-> rises_ff == 4'h8)
    else $error("data out released before eighth bit");
  a_sclk_still_idle:
    assert property (cs_n && $past(cs_n) |-> $stable(sclk))
    else $error("serial clock moved outside a frame");

  c_addressed: cover property ($rose(miso_oe));
  c_int_set: cover property ($fell(int_n));
  c_int_clear: cover property ($rose(int_n));
endmodule // dcsc_assertions

// file: dcsc_tb.sv
// Self-checking bench joining the host and device ends back to back.
// Assumes both ends share clk and reset; card inputs come from here.
`timescale 1ns/10ps
module dcsc_tb;
  logic clk, reset, cmd_valid, cmd_ready, rsp_valid, int_pending;
  logic hw_address_pin, int_hi, deact_seen, watch_clr;
  logic [7:0] cmd_byte, rsp_byte, r;
  logic [1:0] card_detect_switch, det_present_high, card_io_level;
  logic [1:0] supply_fault, card_deactivation_seq;
  logic [3:0] card_supply;
  logic [5:0] card_ctrl;
  int err_total = 0;
  int checks = 0;

  // --------------------------------------------------------------
  // Ends, link and checker
  // --------------------------------------------------------------
  dcsc_spi_if spi_if();
  dcsc_card_host #(.HALF_CYC(dcsc_pkg::SCLK_HALF_CYC), .SCLK_IDLE(1'b0))
    dcsc_card_host_i (.clk(clk), .reset(reset), .spi(spi_if),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .int_pending(int_pending));
  dcsc_card_dev dcsc_card_dev_i (.clk(clk), .reset(reset), .spi(spi_if),
    .hw_address_pin(hw_address_pin),
    .card_detect_switch(card_detect_switch),
    .det_present_high(det_present_high), .card_io_level(card_io_level),
    .supply_fault(supply_fault), .card_supply(card_supply),
    .card_ctrl(card_ctrl), .card_deactivation_seq(card_deactivation_seq));
  dcsc_assertions dcsc_assertions_i (.clk(clk), .reset(reset),
    .sclk(spi_if.sclk), .cs_n(spi_if.cs_n), .mosi(spi_if.mosi),
    .miso_oe(spi_if.miso_oe), .int_n(spi_if.int_n));

  // --------------------------------------------------------------
  // Clock, watchdog and event catchers
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // About 10 frames of 80 cycles; over twenty times that is a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  // Catchers have one driver; the sequence only asks for a clear
  always @(posedge clk)
  begin
    if (watch_clr)
    begin
      int_hi <= 1'b0;
      deact_seen <= 1'b0;
    end
    else
    begin
      if (spi_if.int_n === 1'b1)
        int_hi <= 1'b1;
      if (card_deactivation_seq !== 2'h0)
        deact_seen <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One command byte per frame; waits for the reply, then settles
  task automatic send(input logic [7:0] b, output logic [7:0] rsp);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 400);
    if (n >= 400)
      err_total++;
    rsp = rsp_byte;
    idle(10);
  endtask

  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    hw_address_pin = 1'b0;
    card_detect_switch = 2'h0;
    det_present_high = 2'h3;
    card_io_level = 2'h1;
    supply_fault = 2'h0;
    watch_clr = 1'b1;
    idle(12);
    reset = 1'b0;
    watch_clr = 1'b0;
    idle(6);
    check(spi_if.int_n, 8'h01);
    card_detect_switch = 2'h1;
    idle(10);
    check({spi_if.cs_n, spi_if.int_n}, 8'h02);
    check(int_pending, 8'h01);
    send(8'h00, r);
    check(r, 8'h18);
    send(8'h20, r);
    check(r, 8'h00);
    check(spi_if.int_n, 8'h00);
    send(8'h1D, r);
    check(spi_if.int_n, 8'h01);
    check({card_ctrl[2:0], card_supply[1:0]}, 8'h1D);
    send(8'h42, r);
    check(r, 8'h00);
    send(8'h82, r);
    check(card_supply, 8'h01);
    // Second chip address: the pin flips which bytes are ours
    hw_address_pin = 1'b1;
    send(8'h42, r);
    check(r, 8'h19);
    check(card_supply, 8'h02);
    hw_address_pin = 1'b0;
    card_detect_switch = 2'h0;
    idle(10);
    check(spi_if.int_n, 8'h00);
    check({deact_seen, card_supply}, 8'h10);
    watch_clr = 1'b1;
    idle(1);
    watch_clr = 1'b0;
    card_detect_switch = 2'h1;
    idle(10);
    check(int_hi, 8'h00);
    send(8'h01, r);
    check(spi_if.int_n, 8'h00);
    send(8'h00, r);
    check(spi_if.int_n, 8'h01);
    supply_fault = 2'h2;
    idle(10);
    check(spi_if.int_n, 8'h00);
    check({deact_seen, card_supply}, 8'h10);
    send(8'h21, r);
    check(r, 8'h04);
    check(card_supply, 8'h04);
    check(spi_if.int_n, 8'h00);
    send(8'h20, r);
    check(spi_if.int_n, 8'h01);
    summarize();
  end
endmodule // dcsc_tb
